// *** sdc_sdram.sv ***
// Two-bank synchronous DRAM device: command decode, bursts, power states
`timescale 1ns/1ps
// Overview of operation
// - All inputs but reset taken on rising clock edge only; reset acts at once
// - Two banks of 2048 rows, 256 words
// - Burst length 1,2,4,8 or page; stoppable
// - Auto precharge closes row on last beat of a fixed-length burst
// - Read latency one, two or three cycles
// - Burst order linear or interleaved
// - Clock gate low freezes output and burst
// - Self refresh: refresh with gate low, idle
// - Power down ignores inputs until gate rises
// - Row on bits 0-10; column 0-7, bit 10
// - Close with bit 10 high closes both
// - Mode load stores address as mode
// - Select high ignores the command
// - Row strobe, write high: open row
// - Row strobe, write low: close row
// - Column strobe low: read or write
// - Byte masks block writes, blank reads later
module sdc_sdram (
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    input  wire logic                          i_ce,
    input  wire logic                          i_cke,
    input  wire logic                          i_cs_n,
    input  wire logic                          i_row_strobe_n,
    input  wire logic                          i_col_strobe_n,
    input  wire logic                          i_write_strobe_n,
    input  wire logic [sdc_pkg::ADDR_W-1:0]    i_addr,
    input  wire logic                          i_low_byte_mask,
    input  wire logic                          i_high_byte_mask,
    input  wire logic [sdc_pkg::DATA_W-1:0]    i_data_lines,
    output logic      [sdc_pkg::DATA_W-1:0]    o_data_lines,
    output logic      [1:0]                    o_data_lines_oe,
    output logic      [sdc_pkg::BANKS-1:0]     o_bank_open,
    output logic                               o_power_down,
    output logic                               o_self_refresh
);
    import sdc_pkg::*;

    localparam int MEM_AW = $clog2(BANKS) + ROW_W + COL_W;

    sdc_cmd_t            cmd_raw;
    sdc_cmd_t            cmd;
    sdc_pwr_t            pwr_q;
    logic                cke_prev_q;
    logic                live_w;
    logic [ADDR_W-1:0]   mode_q;
    logic [2:0]          bl_w;
    logic [2:0]          cl_w;
    logic                bank_w;
    logic [BANKS-1:0]    bank_act;
    logic [BANKS-1:0]    bank_idle;
    logic [BANKS-1:0]    ap_close;
    logic [ROW_W-1:0]    bank_row [BANKS];
    logic                both_idle;
    logic                col_cmd;
    logic                kill_w;
    logic                burst_q;
    logic                wr_q;
    logic                bk_q;
    logic                ap_q;
    logic [COL_W-1:0]    start_q;
    logic [COL_W-1:0]    idx_q;
    logic                beat_go;
    logic                beat_wr;
    logic                beat_bk;
    logic                beat_ap;
    logic [COL_W-1:0]    beat_start;
    logic [COL_W-1:0]    beat_idx;
    logic [COL_W-1:0]    beat_col;
    logic                beat_last;
    logic                rd_beat;
    logic [MEM_AW-1:0]   mem_idx;
    logic [DATA_W-1:0]   rd_word;
    logic [1:0]          mask_w;
    logic [1:0]          mask_q;
    logic [1:0]          pipe_v_q;
    logic [DATA_W-1:0]   pipe0_q;
    logic [DATA_W-1:0]   pipe1_q;

    ////////////////////////////////////////////////////////////////////////
    // Command decode and qualification
    ////////////////////////////////////////////////////////////////////////
    sdc_cmd_dec u_dec (
        .i_cs_n (i_cs_n),
        .i_ras_n(i_row_strobe_n),
        .i_cas_n(i_col_strobe_n),
        .i_we_n (i_write_strobe_n),
        .o_cmd  (cmd_raw)
    );

    // Commands count only with the gate high last edge and not asleep
    assign live_w    = i_ce && cke_prev_q;
    assign cmd       = (cke_prev_q && pwr_q == PW_RUN) ? cmd_raw : CMD_DESEL;
    assign bank_w    = i_addr[BANK_BIT];
    assign bl_w      = mode_q[MODE_BL_LSB +: 3];
    assign cl_w      = mode_q[MODE_CL_LSB +: 3];
    assign both_idle = &bank_idle;
    assign mask_w    = {i_high_byte_mask, i_low_byte_mask};

    // Previous gate level, sampled on the rising edge only
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cke_prev_q <= 1'b0;
        end else if (i_ce) begin
            cke_prev_q <= i_cke;
        end
    end

    // Mode register load, only with both banks idle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_q <= MODE_RST;
        end else if (i_ce && cmd == CMD_MODE_LOAD && both_idle && !burst_q) begin
            mode_q <= i_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-bank row state
    ////////////////////////////////////////////////////////////////////////
    for (genvar b = 0; b < BANKS; b++) begin : bank_g
        sdc_bank_t        st_q;
        logic [ROW_W-1:0] row_q;
        logic [3:0]       cnt_q;
        logic             close_w;
        logic             open_q;

        // Single-bank close, or close-all with bit 10
        assign close_w = (cmd == CMD_ROW_CLOSE) && (i_addr[AP_BIT] || bank_w == 1'(b));

        // Idle, open and precharging states of one bank
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                st_q  <= BK_IDLE;
                row_q <= '0;
                cnt_q <= '0;
                open_q <= 1'b0;
            end else if (i_ce) begin
                unique case (st_q)
                    BK_IDLE: begin
                        if (cmd == CMD_ROW_OPEN && bank_w == 1'(b)) begin
                            st_q  <= BK_ACTIVE;
                            open_q <= 1'b1;
                            row_q <= i_addr[ROW_W-1:0];
                        end
                    end
                    BK_ACTIVE: begin
                        if (close_w || ap_close[b]) begin
                            st_q  <= BK_PRECH;
                            open_q <= 1'b0;
                            cnt_q <= RP_CYC - 4'h1;
                        end
                    end
                    BK_PRECH: begin
                        if (cnt_q == 4'h0) begin
                            st_q <= BK_IDLE;
                        end else begin
                            cnt_q <= cnt_q - 4'h1;
                        end
                    end
                endcase
            end
        end

        assign bank_act[b]    = (st_q == BK_ACTIVE);
        assign bank_idle[b]   = (st_q == BK_IDLE);
        assign bank_row[b]    = row_q;
        // Open flag kept in its own flop so the port is registered
        assign o_bank_open[b] = open_q;
        // Auto precharge fires on the last beat of its burst
        assign ap_close[b]    = live_w && beat_go && beat_last && beat_ap && beat_bk == 1'(b);
    end

    ////////////////////////////////////////////////////////////////////////
    // Burst engine
    ////////////////////////////////////////////////////////////////////////
    // Column access needs the addressed bank open
    assign col_cmd = (cmd == CMD_READ || cmd == CMD_WRITE) && bank_act[bank_w];
    assign kill_w  = (cmd == CMD_BURST_STOP) ||
                     (cmd == CMD_ROW_CLOSE && (i_addr[AP_BIT] || bank_w == bk_q));

    // Current beat comes from a new command or the running burst
    assign beat_go    = col_cmd || (burst_q && !kill_w);
    assign beat_wr    = col_cmd ? (cmd == CMD_WRITE) : wr_q;
    assign beat_bk    = col_cmd ? bank_w : bk_q;
    assign beat_ap    = col_cmd ? i_addr[AP_BIT] : ap_q;
    assign beat_start = col_cmd ? i_addr[COL_W-1:0] : start_q;
    assign beat_idx   = col_cmd ? '0 : idx_q;
    assign rd_beat    = beat_go && !beat_wr;

    sdc_burst_col #(
        .COL_W(COL_W)
    ) u_col (
        .i_start     (beat_start),
        .i_idx       (beat_idx),
        .i_len       (bl_w),
        .i_interleave(mode_q[MODE_BT_BIT]),
        .o_col       (beat_col),
        .o_last      (beat_last)
    );

    // Burst state advances only while the gate was high
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            burst_q <= 1'b0;
            wr_q    <= 1'b0;
            bk_q    <= 1'b0;
            ap_q    <= 1'b0;
            start_q <= '0;
            idx_q   <= '0;
        end else if (live_w) begin
            if (col_cmd) begin
                burst_q <= !beat_last;
                wr_q    <= (cmd == CMD_WRITE);
                bk_q    <= bank_w;
                ap_q    <= i_addr[AP_BIT];
                start_q <= i_addr[COL_W-1:0];
                idx_q   <= COL_W'(1);
            end else if (burst_q) begin
                if (kill_w || beat_last) begin
                    burst_q <= 1'b0;
                end else begin
                    idx_q <= idx_q + COL_W'(1);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage, one byte lane per loop pass
    ////////////////////////////////////////////////////////////////////////
    assign mem_idx = {beat_bk, bank_row[beat_bk], beat_col};

    for (genvar g = 0; g < 2; g++) begin : lane_g
        logic [7:0] mem [2**MEM_AW];

        // Masked byte keeps its old contents
        always_ff @(posedge i_clk) begin
            if (live_w && beat_go && beat_wr && !mask_w[g]) begin
                mem[mem_idx] <= i_data_lines[8*g +: 8];
            end
        end

        assign rd_word[8*g +: 8] = mem[mem_idx];
    end

    ////////////////////////////////////////////////////////////////////////
    // Read latency pipe and output stage
    ////////////////////////////////////////////////////////////////////////
    // Two delay stages behind the beat
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pipe_v_q <= '0;
            pipe0_q  <= '0;
            pipe1_q  <= '0;
        end else if (live_w) begin
            pipe_v_q <= {pipe_v_q[0], rd_beat};
            pipe0_q  <= rd_word;
            pipe1_q  <= pipe0_q;
        end
    end

    // Output taps the pipe at the programmed latency
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mask_q          <= '0;
            o_data_lines    <= '0;
            o_data_lines_oe <= '0;
        end else if (live_w) begin
            mask_q <= mask_w;
            case (cl_w)
                CL_1: begin
                    o_data_lines    <= rd_word;
                    o_data_lines_oe <= {2{rd_beat}} & ~mask_q;
                end
                CL_2: begin
                    o_data_lines    <= pipe0_q;
                    o_data_lines_oe <= {2{pipe_v_q[0]}} & ~mask_q;
                end
                default: begin
                    o_data_lines    <= pipe1_q;
                    o_data_lines_oe <= {2{pipe_v_q[1]}} & ~mask_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power down and self refresh
    ////////////////////////////////////////////////////////////////////////
    // Any edge with the gate high wakes the device
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pwr_q          <= PW_RUN;
            o_power_down   <= 1'b0;
            o_self_refresh <= 1'b0;
        end else if (i_ce) begin
            unique case (pwr_q)
                PW_RUN: begin
                    if (cke_prev_q && !i_cke && cmd == CMD_REFRESH && both_idle) begin
                        pwr_q          <= PW_SELF;
                        o_self_refresh <= 1'b1;
                    end else if (cke_prev_q && !i_cke && !burst_q &&
                                 (cmd == CMD_DESEL || cmd == CMD_NOP)) begin
                        pwr_q        <= PW_DOWN;
                        o_power_down <= 1'b1;
                    end
                end
                PW_DOWN, PW_SELF: begin
                    if (i_cke) begin
                        pwr_q          <= PW_RUN;
                        o_power_down   <= 1'b0;
                        o_self_refresh <= 1'b0;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence rd1_s;
        live_w && col_cmd && cmd == CMD_READ && cl_w == CL_1;
    endsequence
    sequence rd3_s;
        live_w && col_cmd && cmd == CMD_READ && cl_w == CL_3;
    endsequence
    sequence wr4_s;
        live_w && col_cmd && cmd == CMD_WRITE && bl_w == BL_4;
    endsequence
    sequence nop3_s;
        (live_w && cmd == CMD_NOP) [*3];
    endsequence

    mode_load_a: assert property (
        (i_ce && cke_prev_q && pwr_q == PW_RUN && !i_cs_n && !i_row_strobe_n && !i_col_strobe_n &&
         !i_write_strobe_n && both_idle && !burst_q) |=> mode_q == $past(i_addr))
        else $error("mode not loaded from address");
    cs_mask_a: assert property (
        (i_cs_n && both_idle) |=> both_idle && $stable(mode_q))
        else $error("command taken with select high");
    row_open_a: assert property (
        (live_w && pwr_q == PW_RUN && !i_cs_n && !i_row_strobe_n && i_col_strobe_n && i_write_strobe_n &&
         !i_addr[BANK_BIT] && bank_idle[0]) |=> bank_act[0] && bank_row[0] == $past(i_addr[ROW_W-1:0]))
        else $error("row open not taken");
    close_all_a: assert property (
        (live_w && cmd == CMD_ROW_CLOSE && i_addr[AP_BIT]) |=> bank_act == '0 ##1 1'b1)
        else $error("close all left a bank open");
    suspend_a: assert property (
        (i_ce && !cke_prev_q) |=> $stable(o_data_lines) && $stable(o_data_lines_oe) && $stable(idx_q))
        else $error("state moved in clock suspend");
    lat1_a: assert property (
        (live_w && mask_w == 2'h0) ##1 rd1_s |=> o_data_lines_oe == 2'h3)
        else $error("latency one read data missing");
    lat3_a: assert property (
        rd3_s ##1 (live_w && mask_w == 2'h0) ##1 live_w |=> o_data_lines_oe == 2'h3)
        else $error("latency three read data missing");
    high_mask_a: assert property (
        (live_w && i_high_byte_mask) ##1 live_w |=> !o_data_lines_oe[1])
        else $error("upper byte not blanked");
    burst4_a: assert property (
        wr4_s ##1 nop3_s |=> !burst_q && $past(burst_q, 2))
        else $error("length four burst wrong length");
    auto_pre_a: assert property (
        (live_w && col_cmd && i_addr[AP_BIT] && !bank_w && bl_w == BL_1) |=> !bank_act[0])
        else $error("auto precharge did not close row");
    self_ref_a: assert property (
        (i_ce && cke_prev_q && pwr_q == PW_RUN && !i_cke && cmd == CMD_REFRESH && both_idle)
        |=> o_self_refresh && !o_power_down)
        else $error("self refresh not entered");
    pdown_a: assert property (
        (o_power_down && !i_cke) |=> $stable(mode_q) && $stable(bank_act))
        else $error("command taken in power down");
endmodule : sdc_sdram

// *** sdc_pkg.sv ***
// Constants and types shared by the synchronous DRAM command model
package sdc_pkg;
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 12;
    localparam int ROW_W    = 11;
    localparam int COL_W    = 8;
    localparam int BANKS    = 2;
    localparam int BANK_BIT = 11; // bank_select_bit position
    localparam int AP_BIT   = 10; // Auto precharge / close-all bit

    // Mode register layout
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BT_BIT = 3;
    localparam int MODE_CL_LSB = 4;
    localparam logic [ADDR_W-1:0] MODE_RST = 12'h010; // Latency 1, length 1, linear

    // Burst length codes
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;

    // Read latency codes
    localparam logic [2:0] CL_1 = 3'h1;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_3 = 3'h3;

    // Precharge time in ns and the derived cycle count
    localparam int CLK_NS  = 50;
    localparam int T_RP_NS = 20;
    localparam logic [3:0] RP_CYC = 4'((T_RP_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [3:0] {
        CMD_DESEL, CMD_NOP, CMD_ROW_OPEN, CMD_ROW_CLOSE, CMD_READ,
        CMD_WRITE, CMD_MODE_LOAD, CMD_REFRESH, CMD_BURST_STOP
    } sdc_cmd_t;

    typedef enum logic [1:0] {BK_IDLE, BK_ACTIVE, BK_PRECH} sdc_bank_t;

    typedef enum logic [1:0] {PW_RUN, PW_DOWN, PW_SELF} sdc_pwr_t;
endpackage : sdc_pkg

// *** sdc_cmd_dec.sv ***
// Strobe decoder turning select, row, column and write strobes into a command
`timescale 1ns/1ps
module sdc_cmd_dec (
    input  wire logic       i_cs_n,
    input  wire logic       i_ras_n,
    input  wire logic       i_cas_n,
    input  wire logic       i_we_n,
    output sdc_pkg::sdc_cmd_t o_cmd
);
    import sdc_pkg::*;

    // Select high masks everything, else the three strobes pick the command
    always_comb begin
        if (i_cs_n) begin
            o_cmd = CMD_DESEL;
        end else begin
            unique case ({i_ras_n, i_cas_n, i_we_n})
                3'b011: o_cmd = CMD_ROW_OPEN;
                3'b010: o_cmd = CMD_ROW_CLOSE;
                3'b101: o_cmd = CMD_READ;
                3'b100: o_cmd = CMD_WRITE;
                3'b000: o_cmd = CMD_MODE_LOAD;
                3'b001: o_cmd = CMD_REFRESH;
                3'b110: o_cmd = CMD_BURST_STOP;
                3'b111: o_cmd = CMD_NOP;
            endcase
        end
    end
endmodule : sdc_cmd_dec

// *** sdc_burst_col.sv ***
// Column sequencer for one burst beat: linear or interleaved order
`timescale 1ns/1ps
module sdc_burst_col #(
    parameter int COL_W = sdc_pkg::COL_W
) (
    input  wire logic [COL_W-1:0] i_start,
    input  wire logic [COL_W-1:0] i_idx,
    input  wire logic [2:0]       i_len,
    input  wire logic             i_interleave,
    output logic      [COL_W-1:0] o_col,
    output logic                  o_last
);
    import sdc_pkg::*;

    logic [COL_W-1:0] wrap;
    logic             page;

    // Wrap mask from the length code; unused codes act as full page
    always_comb begin
        page = 1'b0;
        case (i_len)
            BL_1:    wrap = '0;
            BL_2:    wrap = COL_W'(1);
            BL_4:    wrap = COL_W'(3);
            BL_8:    wrap = COL_W'(7);
            default: begin
                wrap = '1;
                page = 1'b1;
            end
        endcase
        if (i_interleave && !page) begin
            o_col = i_start ^ i_idx;
        end else begin
            o_col = (i_start & ~wrap) | ((i_start + i_idx) & wrap);
        end
        o_last = !page && (i_idx == wrap);
    end
endmodule : sdc_burst_col

// *** sdc_ctrl_model.sv ***
// Memory controller model: command code to select and strobe lines
`timescale 1ns/1ps
module sdc_ctrl_model (
    input  wire logic [3:0] i_op,
    output logic            o_cs_n,
    output logic            o_row_strobe_n,
    output logic            o_col_strobe_n,
    output logic            o_write_strobe_n
);
    logic [3:0] strobes;

    // Pattern {select, row, column, write}; empty edges get a no-op
    always_comb begin
        case (i_op)
            4'h1:    strobes = 4'b0011;
            4'h2:    strobes = 4'b0010;
            4'h3:    strobes = 4'b0101;
            4'h4:    strobes = 4'b0100;
            4'h5:    strobes = 4'b0000;
            4'h6:    strobes = 4'b0001;
            4'h7:    strobes = 4'b1011;
            default: strobes = 4'b0111;
        endcase
    end

    assign {o_cs_n, o_row_strobe_n, o_col_strobe_n, o_write_strobe_n} = strobes;
endmodule : sdc_ctrl_model

// *** test_sdram_command_interface.sv ***
// Self-checking bench for the two-bank DRAM command block
`timescale 1ns/1ps
module test_sdram_command_interface;
    logic        clk, rst, cke, hm, lm;
    logic        pd, sr, cs_n, ras_n, cas_n, we_n;
    logic [3:0]  op;
    logic [11:0] addr;
    logic [15:0] wd, rdat, dq;
    logic [1:0]  oe, bo;
    int          failures, n_compared;

    // Data wire: each byte from whichever side drives it
    assign dq = {oe[1] ? rdat[15:8] : wd[15:8], oe[0] ? rdat[7:0] : wd[7:0]};

    // Clock, 50 ns period
    always #25 clk = ~clk;

    sdc_ctrl_model ctrl (.i_op(op), .o_cs_n(cs_n), .o_row_strobe_n(ras_n), .o_col_strobe_n(cas_n),
        .o_write_strobe_n(we_n));

    sdc_sdram dut (.i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_cke(cke), .i_cs_n(cs_n),
        .i_row_strobe_n(ras_n), .i_col_strobe_n(cas_n), .i_write_strobe_n(we_n), .i_addr(addr),
        .i_low_byte_mask(lm), .i_high_byte_mask(hm), .i_data_lines(dq), .o_data_lines(rdat),
        .o_data_lines_oe(oe), .o_bank_open(bo), .o_power_down(pd), .o_self_refresh(sr));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Inputs change just after the edge and are taken on the next one
    task automatic cmd(input logic [3:0] o, input logic [11:0] a, input logic [15:0] d, input logic h,
        input logic l);
        @(posedge clk);
        #2;
        op = o;
        addr = a;
        wd = d;
        hm = h;
        lm = l;
    endtask : cmd

    task automatic nop();
        cmd(4'h0, 12'h000, 16'h0000, 1'b0, 1'b0);
    endtask : nop

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic wr(input logic [11:0] a, input logic [63:0] d, input logic [3:0] mh, input logic [3:0] ml);
        cmd(4'h4, a, d[15:0], mh[0], ml[0]);
        for (int i = 1; i < 4; i++) begin
            cmd(4'h0, 12'h000, d[16*i+:16], mh[i], ml[i]);
        end
        nop();
    endtask : wr

    task automatic rd(input logic [11:0] a, input int lat, input logic [63:0] e);
        cmd(4'h3, a, 16'h0000, 1'b0, 1'b0);
        nop();
        tick(lat - 1);
        chk(16'(oe), 16'h0003);
        for (int i = 0; i < 4; i++) begin
            chk(rdat, e[16*i+:16]);
            tick(1);
        end
    endtask : rd

    task automatic t_reset();
        chk(16'({bo, pd, sr}), 16'h0000);
    endtask : t_reset

    task automatic t_open_write_read();
        cmd(4'h5, 12'h022, 16'h0000, 1'b0, 1'b0);
        cmd(4'h1, 12'h005, 16'h0000, 1'b0, 1'b0);
        cmd(4'h1, 12'h805, 16'h0000, 1'b0, 1'b0);
        nop();
        chk(16'(bo), 16'h0003);
        wr(12'h008, {16'h1103, 16'h1102, 16'h1101, 16'h1100}, 4'h0, 4'h0);
        wr(12'h008, {16'h22a3, 16'h22a2, 16'h22a1, 16'h22a0}, 4'h2, 4'h8);
        rd(12'h009, 2, {16'h22a0, 16'h2203, 16'h22a2, 16'h11a1});
    endtask : t_open_write_read

    task automatic t_close_all();
        cmd(4'h2, 12'h400, 16'h0000, 1'b0, 1'b0);
        nop();
        tick(2);
        chk(16'(bo), 16'h0000);
        cmd(4'h7, 12'h005, 16'h0000, 1'b0, 1'b0);
        nop();
        tick(1);
        chk(16'(bo), 16'h0000);
    endtask : t_close_all

    task automatic t_interleave_autoclose();
        cmd(4'h5, 12'h03a, 16'h0000, 1'b0, 1'b0);
        cmd(4'h1, 12'h005, 16'h0000, 1'b0, 1'b0);
        nop();
        rd(12'h409, 3, {16'h22a2, 16'h2203, 16'h22a0, 16'h11a1});
        tick(3);
        chk(16'(bo), 16'h0000);
    endtask : t_interleave_autoclose

    // Latency one read, gate dropped for two edges mid-burst
    task automatic t_suspend();
        cmd(4'h5, 12'h012, 16'h0000, 1'b0, 1'b0);
        cmd(4'h1, 12'h005, 16'h0000, 1'b0, 1'b0);
        nop();
        cmd(4'h3, 12'h008, 16'h0000, 1'b0, 1'b0);
        nop();
        chk(16'(oe), 16'h0003);
        chk(rdat, 16'h22a0);
        cke = 1'b0;
        tick(1);
        chk(rdat, 16'h11a1);
        tick(1);
        chk(rdat, 16'h11a1);
        cke = 1'b1;
        tick(1);
        chk(rdat, 16'h11a1);
        tick(1);
        chk(rdat, 16'h22a2);
        tick(1);
        chk(rdat, 16'h2203);
        tick(1);
        chk(16'(oe), 16'h0000);
        cmd(4'h2, 12'h000, 16'h0000, 1'b0, 1'b0);
        nop();
        chk(16'(bo), 16'h0000);
    endtask : t_suspend

    task automatic t_power();
        tick(1);
        cke = 1'b0;
        tick(2);
        chk(16'({pd, sr}), 16'h0002);
        cke = 1'b1;
        tick(2);
        chk(16'({pd, sr}), 16'h0000);
        cmd(4'h6, 12'h000, 16'h0000, 1'b0, 1'b0);
        cke = 1'b0;
        nop();
        tick(1);
        chk(16'({pd, sr}), 16'h0001);
        cke = 1'b1;
        tick(2);
        chk(16'({pd, sr}), 16'h0000);
    endtask : t_power

    task automatic complete_run();
        $display("Checks made %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // Hang guard
    initial begin
        #100000;
        failures++;
        complete_run();
    end

    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        cke = 1'b1;
        op = 4'h0;
        addr = 12'h000;
        wd = 16'h0000;
        hm = 1'b0;
        lm = 1'b0;
        failures = 0;
        n_compared = 0;
        tick(6);
        rst = 1'b0;
        t_reset();
        t_open_write_read();
        t_close_all();
        t_interleave_autoclose();
        t_suspend();
        t_power();
        complete_run();
    end
endmodule : test_sdram_command_interface
